// ---- scs_initiator.sv ----
`timescale 1ns/10ps
module scs_initiator (
  input  wire       clk_i,
  input  wire       stall_i,
  output reg        cmd_valid_o = 1'b0,
  input  wire       cmd_ready_i,
  output reg  [7:0] cmd_op_o = 8'h00,
  output reg  [7:0] cmd_alloc_o = 8'h00,
  output reg  [2:0] cmd_init_o = 3'h0,
  input  wire       din_valid_i,
  output wire       din_ready_o,
  input  wire [7:0] din_data_i,
  input  wire       sts_valid_i,
  input  wire [7:0] sts_data_i
);
  reg [7:0] got_q [$];
  reg [7:0] sts_q = 8'h00;
  reg       sts_seen = 1'b0;
  assign din_ready_o = ~stall_i;
  always @(posedge clk_i)
  begin
    if (din_valid_i && din_ready_o)
      got_q.push_back(din_data_i);
    if (sts_valid_i)
    begin
      sts_q <= sts_data_i;
      sts_seen <= 1'b1;
    end
  end
  task send(input [7:0] op, input [7:0] al, input [2:0] in);
    begin
      sts_seen = 1'b0;
      got_q.delete();
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_op_o <= op;
      cmd_alloc_o <= al;
      cmd_init_o <= in;
      @(posedge clk_i);
      while (cmd_ready_i !== 1'b1) @(posedge clk_i);
      // released lines show garbage, not the last command
      cmd_valid_o <= 1'b0;
      cmd_op_o <= ~op;
      cmd_alloc_o <= ~al;
      cmd_init_o <= ~in;
    end
  endtask
  task wait_sts;
    while (sts_seen !== 1'b1) @(posedge clk_i);
  endtask
endmodule // scs_initiator

// ---- scs_mem.v ----
`timescale 1ns/10ps
`include "scs_regs.vh"

module scs_mem #(
  parameter AW = 3,
  parameter DW = `SCS_ENT_W
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output wire [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_ff [0:(1<<AW)-1];
  reg [DW-1:0] rdata_ff;
  integer      i;

  // entries start cleared so every initiator first sees no-sense
  initial
  begin
    for (i = 0; i < (1<<AW); i = i + 1)
      mem_ff[i] = {DW{1'b0}};
  end

  always @(posedge clk_i)
  begin
    if (we_i)
      mem_ff[waddr_i] <= wdata_i;
    rdata_ff <= mem_ff[raddr_i];
  end

  assign rdata_o = rdata_ff;

endmodule // scs_mem

// ---- scs_regs.vh ----
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// register byte offsets and reset values
`define SCS_CTRL_OFF      8'h00
`define SCS_STAT_OFF      8'h04
`define SCS_CMD_OFF       8'h08
`define SCS_RES_OFF       8'h0C
`define SCS_INFO_OFF      8'h10
`define SCS_POS_OFF       8'h14
`define SCS_CTRL_RST      6'h00
`define SCS_POS_RST       20'h00000

// control bits
`define SCS_CTRL_SELFTEST 0
`define SCS_CTRL_MOTOR    1
`define SCS_CTRL_LOADED   2
`define SCS_CTRL_LOADFAIL 3
`define SCS_CTRL_CALIB    4
`define SCS_CTRL_SPINUP   5

// result register fields
`define SCS_RES_KEY       3:0
`define SCS_RES_ILI       4
`define SCS_RES_VALID     5
`define SCS_RES_ASC       15:8
`define SCS_RES_ASCQ      23:16
`define SCS_RES_CAUSE     26:24
`define SCS_CAUSE_NONE    3'h0
`define SCS_CAUSE_ECC     3'h1
`define SCS_CAUSE_SEEK    3'h2
`define SCS_CAUSE_SEQ     3'h3
`define SCS_CAUSE_NOSPEED 3'h4
`define SCS_CAUSE_SPDRNG  3'h5

// opcodes
`define SCS_OP_TUR        8'h00
`define SCS_OP_REZERO     8'h01
`define SCS_OP_RSENSE     8'h03
`define SCS_OP_INQUIRY    8'h12
`define SCS_OP_RESERVE    8'h16
`define SCS_OP_RELEASE    8'h17
`define SCS_OP_STARTSTOP  8'h1B
`define SCS_OP_SENDDIAG   8'h1D
`define SCS_OP_WRBUF      8'h3B
`define SCS_OP_RDBUF      8'h3C
`define SCS_OP_RDLONG     8'h3E
`define SCS_OP_WRLONG     8'h3F

// status bytes, keys, codes
`define SCS_ST_GOOD       8'h00
`define SCS_ST_CHECK      8'h02
`define SCS_KEY_NONE      4'h0
`define SCS_KEY_RECOV     4'h1
`define SCS_KEY_NOTRDY    4'h2
`define SCS_KEY_MEDIUM    4'h3
`define SCS_ASC_NONE      8'h00
`define SCS_ASC_NOTRDY    8'h04
`define SCS_ASCQ_RECAL    8'h00
`define SCS_ASCQ_SPINUP   8'h01
`define SCS_ASC_FMTBAD    8'h31
`define SCS_ASC_ECC       8'h17
`define SCS_ASCQ_ECCFLY   8'h09
`define SCS_ASC_SEEK      8'h15
`define SCS_ASC_SEQ       8'h86
`define SCS_ASC_MOTOR     8'h9E
`define SCS_ASCQ_NOSPEED  8'h00
`define SCS_ASCQ_SPDRNG   8'h01

// sense record format
`define SCS_ERR_CODE      7'h70
`define SCS_ADD_LEN       8'h0A
`define SCS_SENSE_LEN     8'h12

// stored sense entry layout
`define SCS_ENT_W         54
`define SCS_ENT_VALID     53
`define SCS_ENT_ILI       52
`define SCS_ENT_KEY       51:48
`define SCS_ENT_ASC       47:40
`define SCS_ENT_ASCQ      39:32
`define SCS_ENT_INFO      31:0

// timing
`define SCS_CLK_PERIOD_NS 5
`define SCS_PWR_ON_MS     1000
`define SCS_PWR_CYC       (`SCS_PWR_ON_MS * 1000000 / `SCS_CLK_PERIOD_NS)

`endif

// ---- scs_top.v ----
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "scs_regs.vh"

module scs_top #(
  parameter        IW      = 3,
  parameter [31:0] PWR_CYC = `SCS_PWR_CYC
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  input  wire [3:0]    wb_sel_i,
  output wire [31:0]   wb_dat_o,
  output wire          wb_ack_o,
  input  wire          cmd_valid_i,
  output wire          cmd_ready_o,
  input  wire [7:0]    cmd_op_i,
  input  wire [7:0]    cmd_alloc_i,
  input  wire [IW-1:0] cmd_init_i,
  output wire          din_valid_o,
  input  wire          din_ready_i,
  output wire [7:0]    din_data_o,
  output wire          din_last_o,
  output wire          sts_valid_o,
  output wire [7:0]    sts_data_o,
  output wire          rezero_o,
  output wire [15:0]   cyl_o,
  output wire [3:0]    head_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD   = 3'h1;
  localparam [2:0] ST_DEC  = 3'h2;
  localparam [2:0] ST_XFER = 3'h3;
  localparam [2:0] ST_FW   = 3'h4;
  localparam [2:0] ST_STS  = 3'h5;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  reg  [5:0]           ctrl_ff;
  reg  [31:0]          info_ff;
  reg  [19:0]          pos_ff;
  reg                  ack_ff;
  reg  [31:0]          rdat_ff;
  reg  [2:0]           state_ff;
  reg  [7:0]           op_ff;
  reg  [7:0]           alloc_ff;
  reg  [IW-1:0]        init_ff;
  reg  [31:0]          pwr_cnt_ff;
  reg                  pwr_done_ff;
  reg                  rezero_ff;
  wire [31:0]          wmask;
  wire                 bus_rd;
  wire                 bus_wr;
  wire                 res_wr;
  wire                 ready;
  wire [31:0]          res_val;
  reg  [31:0]          nxt_rdat;

  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign bus_rd = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign res_wr = bus_wr & (wb_adr_i == `SCS_RES_OFF);
  assign res_val = wb_dat_i & wmask;

  // all four preparation steps done and tables readable
  assign ready = ctrl_ff[`SCS_CTRL_SELFTEST] & ctrl_ff[`SCS_CTRL_MOTOR] &
                 ctrl_ff[`SCS_CTRL_LOADED] & ctrl_ff[`SCS_CTRL_CALIB] &
                 ~ctrl_ff[`SCS_CTRL_LOADFAIL];

  always @*
  begin
    nxt_rdat = 32'h00000000;
    case (wb_adr_i)
      `SCS_CTRL_OFF: nxt_rdat = {26'h0000000, ctrl_ff};
      `SCS_STAT_OFF: nxt_rdat = {{(24-IW){1'b0}}, init_ff, 4'h0,
                                 ctrl_ff[`SCS_CTRL_LOADFAIL], (state_ff == ST_FW),
                                 pwr_done_ff, ready};
      `SCS_CMD_OFF:  nxt_rdat = {{(16-IW){1'b0}}, init_ff, alloc_ff, op_ff};
      `SCS_INFO_OFF: nxt_rdat = info_ff;
      `SCS_POS_OFF:  nxt_rdat = {12'h000, pos_ff};
      default:       nxt_rdat = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
      ctrl_ff <= `SCS_CTRL_RST;
      info_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= bus_rd;
      if (bus_rd)
        rdat_ff <= nxt_rdat;
      if (bus_wr && wb_adr_i == `SCS_CTRL_OFF)
        ctrl_ff <= (ctrl_ff & ~wmask[5:0]) | (wb_dat_i[5:0] & wmask[5:0]);
      if (bus_wr && wb_adr_i == `SCS_INFO_OFF)
        info_ff <= (info_ff & ~wmask) | res_val;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  //////////////////////////////////////////////////////////////////////////////
  // power-on window

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_cnt_ff  <= 32'h00000000;
      pwr_done_ff <= 1'b0;
    end
    else if (!pwr_done_ff)
    begin
      pwr_cnt_ff  <= pwr_cnt_ff + 32'h00000001;
      pwr_done_ff <= (pwr_cnt_ff >= PWR_CYC - 32'h00000001);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // actuator position

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_ff    <= `SCS_POS_RST;
      rezero_ff <= 1'b0;
    end
    else
    begin
      rezero_ff <= (state_ff == ST_DEC) && (op_ff == `SCS_OP_REZERO) && ready &&
                   !ctrl_ff[`SCS_CTRL_LOADFAIL];
      if (rezero_ff)
        pos_ff <= `SCS_POS_RST;
      else if (bus_wr && wb_adr_i == `SCS_POS_OFF)
        pos_ff <= (pos_ff & ~wmask[19:0]) | res_val[19:0];
    end
  end

  assign rezero_o = rezero_ff;
  assign cyl_o    = pos_ff[15:0];
  assign head_o   = pos_ff[19:16];

  //////////////////////////////////////////////////////////////////////////////
  // sense storage

  wire [`SCS_ENT_W-1:0] rd_ent;
  reg  [`SCS_ENT_W-1:0] ent_ff;
  reg  [`SCS_ENT_W-1:0] nxt_went;
  reg                   nxt_we;
  reg  [3:0]            res_key;
  reg  [7:0]            res_asc;
  reg  [7:0]            res_ascq;
  wire                  long_op;
  wire                  nodisk;

  scs_mem #(
    .AW      (IW),
    .DW      (`SCS_ENT_W)
  ) i_scs_mem (
    .clk_i   (clk_i),
    .we_i    (nxt_we),
    .waddr_i (init_ff),
    .wdata_i (nxt_went),
    .raddr_i (init_ff),
    .rdata_o (rd_ent)
  );

  assign nodisk = (op_ff == `SCS_OP_RSENSE) || (op_ff == `SCS_OP_INQUIRY) ||
                  (op_ff == `SCS_OP_RESERVE) || (op_ff == `SCS_OP_RELEASE) ||
                  (op_ff == `SCS_OP_SENDDIAG) || (op_ff == `SCS_OP_STARTSTOP) ||
                  (op_ff == `SCS_OP_RDBUF) || (op_ff == `SCS_OP_WRBUF);

  assign long_op = (op_ff == `SCS_OP_RDBUF) || (op_ff == `SCS_OP_RDLONG) ||
                   (op_ff == `SCS_OP_WRLONG);

  // recovered causes substitute their fixed key and ASC; ECC and the motor causes fix the ASCQ too
  always @*
  begin
    res_key  = res_val[`SCS_RES_KEY];
    res_asc  = res_val[`SCS_RES_ASC];
    res_ascq = res_val[`SCS_RES_ASCQ];
    case (res_val[`SCS_RES_CAUSE])
      `SCS_CAUSE_ECC:
      begin
        res_key  = `SCS_KEY_RECOV;
        res_asc  = `SCS_ASC_ECC;
        res_ascq = `SCS_ASCQ_ECCFLY;
      end
      `SCS_CAUSE_SEEK:
      begin
        res_key = `SCS_KEY_RECOV;
        res_asc = `SCS_ASC_SEEK;
      end
      `SCS_CAUSE_SEQ:
      begin
        res_key = `SCS_KEY_RECOV;
        res_asc = `SCS_ASC_SEQ;
      end
      `SCS_CAUSE_NOSPEED:
      begin
        res_key  = `SCS_KEY_RECOV;
        res_asc  = `SCS_ASC_MOTOR;
        res_ascq = `SCS_ASCQ_NOSPEED;
      end
      `SCS_CAUSE_SPDRNG:
      begin
        res_key  = `SCS_KEY_RECOV;
        res_asc  = `SCS_ASC_MOTOR;
        res_ascq = `SCS_ASCQ_SPDRNG;
      end
      default:
      begin
        res_key  = res_val[`SCS_RES_KEY];
        res_asc  = res_val[`SCS_RES_ASC];
        res_ascq = res_val[`SCS_RES_ASCQ];
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer

  reg  [2:0]  nxt_state;
  reg  [7:0]  nxt_sts;
  reg  [7:0]  sts_ff;
  reg  [7:0]  len_ff;
  reg  [7:0]  cnt_ff;
  reg  [7:0]  din_ff;
  reg  [7:0]  nxt_byte;
  reg  [7:0]  bidx;
  wire        take;
  wire        beat;
  wire        last_beat;
  wire [7:0]  nxt_len;

  assign take      = cmd_valid_i & cmd_ready_o;
  assign beat      = (state_ff == ST_XFER) & din_ready_i;
  assign last_beat = (cnt_ff == len_ff - 8'h01);
  // truncate to the smaller of allocation and full record
  assign nxt_len   = (alloc_ff < `SCS_SENSE_LEN) ? alloc_ff : `SCS_SENSE_LEN;

  always @*
  begin
    nxt_state = state_ff;
    nxt_sts   = sts_ff;
    nxt_we    = 1'b0;
    nxt_went  = {`SCS_ENT_W{1'b0}};
    case (state_ff)
      ST_IDLE:
        if (take)
          nxt_state = ST_RD;
      ST_RD:
        nxt_state = ST_DEC;
      ST_DEC:
      begin
        // any command from this initiator, retrieval included, rewrites its entry: cleared, or the medium or not-ready sense on failure
        nxt_we  = 1'b1;
        nxt_sts = `SCS_ST_GOOD;
        if (op_ff == `SCS_OP_RSENSE)
          nxt_state = (nxt_len == 8'h00) ? ST_STS : ST_XFER;
        else if (!nodisk && ctrl_ff[`SCS_CTRL_LOADFAIL])
        begin
          nxt_sts                  = `SCS_ST_CHECK;
          nxt_went[`SCS_ENT_KEY]   = `SCS_KEY_MEDIUM;
          nxt_went[`SCS_ENT_ASC]   = `SCS_ASC_FMTBAD;
          nxt_state                = ST_STS;
        end
        else if (!nodisk && !ready)
        begin
          nxt_sts                = `SCS_ST_CHECK;
          nxt_went[`SCS_ENT_KEY] = `SCS_KEY_NOTRDY;
          nxt_went[`SCS_ENT_ASC] = `SCS_ASC_NOTRDY;
          nxt_went[`SCS_ENT_ASCQ] = ctrl_ff[`SCS_CTRL_SPINUP] ?
                                    `SCS_ASCQ_SPINUP : `SCS_ASCQ_RECAL;
          nxt_state              = ST_STS;
        end
        else if (op_ff == `SCS_OP_TUR || op_ff == `SCS_OP_REZERO)
          nxt_state = ST_STS;
        else
          nxt_state = ST_FW;
      end
      ST_XFER:
        if (beat && last_beat)
          nxt_state = ST_STS;
      ST_FW:
        if (res_wr)
        begin
          nxt_we                  = 1'b1;
          nxt_went[`SCS_ENT_VALID] = res_val[`SCS_RES_VALID];
          nxt_went[`SCS_ENT_ILI]  = res_val[`SCS_RES_ILI] & long_op;
          nxt_went[`SCS_ENT_KEY]  = res_key;
          nxt_went[`SCS_ENT_ASC]  = res_asc;
          nxt_went[`SCS_ENT_ASCQ] = res_ascq;
          nxt_went[`SCS_ENT_INFO] = info_ff;
          nxt_sts   = (res_key == `SCS_KEY_NONE) ? `SCS_ST_GOOD : `SCS_ST_CHECK;
          nxt_state = ST_STS;
        end
      ST_STS:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // the entry just read in DEC, the snapshot afterwards
  wire [`SCS_ENT_W-1:0] cur_ent;
  assign cur_ent = (state_ff == ST_DEC) ? rd_ent : ent_ff;

  function ent_sel;
    input integer pos;
    begin
      ent_sel = cur_ent[pos];
    end
  endfunction

  // record byte for the index about to be presented
  always @*
  begin
    bidx = (state_ff == ST_DEC) ? 8'h00 : cnt_ff + 8'h01;
    case (bidx)
      8'h00:   nxt_byte = {ent_sel(`SCS_ENT_VALID), `SCS_ERR_CODE};
      8'h01:   nxt_byte = 8'h00;
      8'h02:   nxt_byte = {2'b00, ent_sel(`SCS_ENT_ILI), 1'b0, cur_ent[`SCS_ENT_KEY]};
      8'h03:   nxt_byte = cur_ent[31:24];
      8'h04:   nxt_byte = cur_ent[23:16];
      8'h05:   nxt_byte = cur_ent[15:8];
      8'h06:   nxt_byte = cur_ent[7:0];
      8'h07:   nxt_byte = `SCS_ADD_LEN;
      8'h0C:   nxt_byte = cur_ent[`SCS_ENT_ASC];
      8'h0D:   nxt_byte = cur_ent[`SCS_ENT_ASCQ];
      default: nxt_byte = 8'h00;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      op_ff    <= 8'h00;
      alloc_ff <= 8'h00;
      init_ff  <= {IW{1'b0}};
      sts_ff   <= `SCS_ST_GOOD;
      ent_ff   <= {`SCS_ENT_W{1'b0}};
      len_ff   <= 8'h00;
      cnt_ff   <= 8'h00;
      din_ff   <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      sts_ff   <= nxt_sts;
      if (take)
      begin
        op_ff    <= cmd_op_i;
        alloc_ff <= cmd_alloc_i;
        init_ff  <= cmd_init_i;
      end
      if (state_ff == ST_DEC)
      begin
        ent_ff <= rd_ent;
        len_ff <= nxt_len;
        cnt_ff <= 8'h00;
        din_ff <= nxt_byte;
      end
      else if (beat)
      begin
        cnt_ff <= cnt_ff + 8'h01;
        din_ff <= nxt_byte;
      end
    end
  end

  assign cmd_ready_o = (state_ff == ST_IDLE) & pwr_done_ff;
  assign din_valid_o = (state_ff == ST_XFER);
  assign din_data_o  = din_ff;
  assign din_last_o  = (state_ff == ST_XFER) & last_beat;
  assign sts_valid_o = (state_ff == ST_STS);
  assign sts_data_o  = sts_ff;

endmodule // scs_top

// ---- scs_top_properties.sv ----
`timescale 1ns/10ps
`include "scs_regs.vh"
module scs_props #(
  parameter        IW      = 3,
  parameter [31:0] PWR_CYC = `SCS_PWR_CYC
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cmd_valid_i,
  input wire        cmd_ready_o,
  input wire [7:0]  cmd_op_i,
  input wire [7:0]  cmd_alloc_i,
  input wire        din_valid_o,
  input wire        din_ready_i,
  input wire [7:0]  din_data_o,
  input wire        din_last_o,
  input wire        sts_valid_o,
  input wire [7:0]  sts_data_o,
  input wire        rezero_o,
  input wire [15:0] cyl_o,
  input wire [3:0]  head_o
);
  reg  [31:0] pwr_ff;
  reg  [7:0]  op_ff;
  reg  [7:0]  lim_ff;
  reg  [7:0]  idx_ff;
  wire        take = cmd_valid_i && cmd_ready_o;
  always @(posedge clk_i)
  begin
    if (rst_i)
      pwr_ff <= 32'h0;
    else if (pwr_ff != 32'hFFFFFFFF)
      pwr_ff <= pwr_ff + 32'h1;
    if (take)
    begin
      op_ff <= cmd_op_i;
      lim_ff <= (cmd_alloc_i > 8'h12) ? 8'h12 : cmd_alloc_i;
      idx_ff <= 8'h00;
    end
    else if (din_valid_o && din_ready_i)
      idx_ff <= idx_ff + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rs; take && cmd_op_i == `SCS_OP_RSENSE; endsequence
  sequence s_good; sts_valid_o && sts_data_o == `SCS_ST_GOOD; endsequence
  property p_tur; take && cmd_op_i == `SCS_OP_TUR |-> ##3 sts_valid_o; endproperty
  a_tur: assert property (p_tur) else $error("tur status late");
  property p_pwr; pwr_ff < PWR_CYC - 32'h1 |-> !cmd_ready_o; endproperty
  a_pwr: assert property (p_pwr) else $error("ready in power window");
  property p_rs0; s_rs ##0 cmd_alloc_i == 8'h00 |-> !din_valid_o [*3] ##1 s_good; endproperty
  a_rs0: assert property (p_rs0) else $error("zero length sent data");
  property p_rs1; s_rs ##0 cmd_alloc_i != 8'h00 |->
    ##3 din_valid_o && din_data_o[6:0] == `SCS_ERR_CODE; endproperty
  a_rs1: assert property (p_rs1) else $error("first sense byte wrong");
  property p_rsg; sts_valid_o && op_ff == `SCS_OP_RSENSE |-> sts_data_o == `SCS_ST_GOOD; endproperty
  a_rsg: assert property (p_rsg) else $error("sense status not good");
  property p_last; din_valid_o && din_last_o |-> idx_ff == lim_ff - 8'h01; endproperty
  a_last: assert property (p_last) else $error("last byte misplaced");
  property p_lastn; din_valid_o && idx_ff == lim_ff - 8'h01 |-> din_last_o; endproperty
  a_lastn: assert property (p_lastn) else $error("last byte not marked");
  property p_len; din_valid_o && idx_ff == 8'h07 |-> din_data_o == `SCS_ADD_LEN; endproperty
  a_len: assert property (p_len) else $error("additional length wrong");
  property p_zero; din_valid_o && (idx_ff == 8'h01 || (idx_ff > 8'h07 && idx_ff < 8'h0C)
    || idx_ff > 8'h0D) |-> din_data_o == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("zero byte not zero");
  property p_rez; rezero_o |->
    op_ff == `SCS_OP_REZERO ##[0:1] cyl_o == 16'h0 && head_o == 4'h0; endproperty
  a_rez: assert property (p_rez) else $error("rezero position wrong");
endmodule // scs_props
bind scs_top scs_props #(.IW(IW), .PWR_CYC(PWR_CYC)) i_scs_props (.clk_i(clk_i), .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
  .cmd_alloc_i(cmd_alloc_i), .din_valid_o(din_valid_o), .din_ready_i(din_ready_i),
  .din_data_o(din_data_o), .din_last_o(din_last_o), .sts_valid_o(sts_valid_o),
  .sts_data_o(sts_data_o), .rezero_o(rezero_o), .cyl_o(cyl_o), .head_o(head_o));

// ---- test_scsi_target_ready_sense.sv ----
`timescale 1ns/10ps
`include "scs_regs.vh"
module test_scsi_target_ready_sense;
  localparam [63:0] FW_OP  = {8'h3E, 8'h3C, 8'h3B, 8'h1D, 8'h1B, 8'h17, 8'h16, 8'h12};
  localparam [63:0] FW_ASC = {8'h03, 8'h03, 8'h00, 8'h9E, 8'h9E, 8'h86, 8'h15, 8'h17};
  localparam [63:0] FW_Q   = {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h09};
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [7:0]  adr = 8'h00, rnd_ff = 8'h5B, al;
  reg  [31:0] wdat = 32'h0, r, res;
  reg  [3:0]  k, m_key [0:7];
  reg  [7:0]  m_asc [0:7], m_ascq [0:7];
  reg         il, m_ili [0:7], m_val [0:7];
  reg  [31:0] m_inf [0:7];
  integer     fails = 0, num_checks = 0, tmo = 0, nrz = 0, i, b, n;
  wire [31:0] rdat;
  wire        ack, c_valid, c_ready, d_valid, d_ready, d_last, s_valid, rz;
  wire [7:0]  c_op, c_alloc, d_data, s_data;
  wire [2:0]  c_init;
  wire [15:0] cyl;
  wire [3:0]  head;
  scs_top #(.IW(3), .PWR_CYC(32'h14)) i_scs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_valid_i(c_valid), .cmd_ready_o(c_ready),
    .cmd_op_i(c_op), .cmd_alloc_i(c_alloc), .cmd_init_i(c_init), .din_valid_o(d_valid),
    .din_ready_i(d_ready), .din_data_o(d_data), .din_last_o(d_last), .sts_valid_o(s_valid),
    .sts_data_o(s_data), .rezero_o(rz), .cyl_o(cyl), .head_o(head));
  scs_initiator i_scs_initiator (.clk_i(clk_i), .stall_i(rnd_ff[0]), .cmd_valid_o(c_valid),
    .cmd_ready_i(c_ready), .cmd_op_o(c_op), .cmd_alloc_o(c_alloc), .cmd_init_o(c_init),
    .din_valid_i(d_valid), .din_ready_o(d_ready), .din_data_i(d_data), .sts_valid_i(s_valid),
    .sts_data_i(s_data));
  always #2.5 clk_i = ~clk_i;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  always @(posedge clk_i)
  begin
    rnd_ff <= lfsr(rnd_ff);
    if (rz) nrz <= nrz + 1;
    tmo <= tmo + 1;
    if (tmo == 20000)
    begin
      fails++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk_b(input string nm, input [7:0] e, input [7:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        fails++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk_w(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        fails++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task setm(input [2:0] in, input [3:0] ky, input [7:0] a, input [7:0] q, input li, input v,
    input [31:0] inf);
    begin
      m_key[in] = ky;
      m_asc[in] = a;
      m_ascq[in] = q;
      m_ili[in] = li;
      m_val[in] = v;
      m_inf[in] = inf;
    end
  endtask
  function [7:0] sb(input [2:0] in, input integer bx);
    case (bx)
      0: sb = {m_val[in], 7'h70};
      2: sb = {2'b00, m_ili[in], 1'b0, m_key[in]};
      3: sb = m_inf[in][31:24];
      4: sb = m_inf[in][23:16];
      5: sb = m_inf[in][15:8];
      6: sb = m_inf[in][7:0];
      7: sb = 8'h0A;
      12: sb = m_asc[in];
      13: sb = m_ascq[in];
      default: sb = 8'h00;
    endcase
  endfunction
  task cmd(input [7:0] op, input [2:0] in, input [7:0] st, input [3:0] ky, input [7:0] a,
    input [7:0] q);
    begin
      i_scs_initiator.send(op, rnd_ff, in);
      i_scs_initiator.wait_sts();
      chk_b("status", st, i_scs_initiator.sts_q);
      setm(in, ky, a, q, 1'b0, 1'b0, 32'h0);
    end
  endtask
  task rs(input [2:0] in, input [7:0] a);
    begin
      i_scs_initiator.send(8'h03, a, in);
      i_scs_initiator.wait_sts();
      n = (a > 8'h12) ? 18 : a;
      chk_w("sense count", n, i_scs_initiator.got_q.size());
      for (b = 0; b < n; b++) chk_b("sense byte", sb(in, b), i_scs_initiator.got_q[b]);
      chk_b("sense status", 8'h00, i_scs_initiator.sts_q);
      setm(in, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0, 32'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 8; i++) setm(i, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0, 32'h0);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk_w("ctrl reset", 32'h0, r);
    wb(1'b0, 8'h14, 32'h0);
    chk_w("pos reset", 32'h0, r);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk_w("unmapped", 32'h0, r);
    $display("test bus done");
    cmd(8'h00, 3'h1, 8'h02, 4'h2, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 32'h35);
    cmd(8'h00, 3'h2, 8'h02, 4'h2, 8'h04, 8'h01);
    wb(1'b1, 8'h00, 32'h1F);
    cmd(8'h01, 3'h3, 8'h02, 4'h3, 8'h31, 8'h00);
    rs(3'h1, 8'h12);
    rs(3'h2, 8'h0E);
    rs(3'h2, 8'h12);
    rs(3'h3, rnd_ff);
    wb(1'b1, 8'h00, 32'h17);
    wb(1'b1, 8'h14, 32'h00051234);
    cmd(8'h00, 3'h4, 8'h00, 4'h0, 8'h00, 8'h00);
    cmd(8'h01, 3'h4, 8'h00, 4'h0, 8'h00, 8'h00);
    chk_w("pos pins", 32'h0, {12'h0, head, cyl});
    wb(1'b0, 8'h14, 32'h0);
    chk_w("pos reg", 32'h0, r);
    chk_w("rezero pulses", 32'h1, nrz);
    $display("test ready done");
    for (i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h00, (i > 6) ? 32'h17 : 32'h0);
      wb(1'b1, 8'h10, (i > 5) ? 32'hA1B2C3D4 : 32'h0);
      al = rnd_ff;
      i_scs_initiator.send(FW_OP[8*i +: 8], al, i[2:0]);
      r = 32'h0;
      while (r[2] !== 1'b1) wb(1'b0, 8'h04, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      chk_w("cmd reg", {13'h0, i[2:0], al, FW_OP[8*i +: 8]}, r);
      k = (i == 5) ? 4'h0 : 4'h1;
      il = (i == 0) || (i > 5);
      res = {5'h0, (i < 5) ? i[2:0] + 3'h1 : 3'h0, FW_Q[8*i +: 8], 16'h0};
      res[15:0] = {(i < 5) ? 8'h00 : FW_ASC[8*i +: 8], 2'b00, i > 5, il, k};
      wb(1'b1, 8'h0C, res);
      i_scs_initiator.wait_sts();
      chk_b("status", (i == 5) ? 8'h00 : 8'h02, i_scs_initiator.sts_q);
      setm(i, k, FW_ASC[8*i +: 8], FW_Q[8*i +: 8], i > 5, i > 5, (i > 5) ? 32'hA1B2C3D4 : 32'h0);
    end
    $display("test firmware done");
    for (i = 0; i < 8; i++)
      rs(i, (i == 5) ? 8'h00 : (i == 6) ? 8'hFF : rnd_ff);
    rs(3'h0, 8'h12);
    $display("test sense done");
    give_verdict;
  end
endmodule // test_scsi_target_ready_sense
